// *** mcss_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Three-stage pin synchroniser; a new level is accepted only once
// the second and third stages agree, so a single metastable sample
// never reaches the block's own logic.
module mcss_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Raw pin levels from outside the clock domain
    input wire logic [W-1:0] pin_raw,
    // Filtered levels in the ref_clk domain
    output logic [W-1:0] pin_level
);

    genvar gi;

    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_bit
            logic s1_ff; // First stage, read only by the second
            logic s2_ff; // Second stage
            logic s3_ff; // Third stage
            logic lvl_ff; // Accepted level
            logic nxt_lvl;

            // Accept the level only when stages two and three agree
            always_comb begin
                nxt_lvl = lvl_ff;
                if (s2_ff == s3_ff) begin
                    nxt_lvl = s3_ff;
                end
            end

            // Register the chain and the accepted level
            always_ff @(posedge ref_clk or posedge rst) begin
                if (rst) begin
                    s1_ff <= 1'b0;
                    s2_ff <= 1'b0;
                    s3_ff <= 1'b0;
                    lvl_ff <= 1'b0;
                end else begin
                    s1_ff <= pin_raw[gi];
                    s2_ff <= s1_ff;
                    s3_ff <= s2_ff;
                    lvl_ff <= nxt_lvl;
                end
            end

            assign pin_level[gi] = lvl_ff;
        end
    endgenerate

endmodule : mcss_sync

`default_nettype wire

// *** mcss_top.sv ***
// Function
// - Master clock output runs at T1 or E1
// - All channels share one common line rate
// - Hardware mode: select pins plus rate configure
// - Hardware mode: rate derived from equalizer inputs
// - Host mode: ignore pins, use host bits
package mcss_pkg;

    // Clock of the block
    localparam int CLK_PERIOD_NS = 50;

    // Reference activity window, in ns and in cycles
    localparam int WIN_TIME_NS = 500000;
    localparam int WIN_CYC = WIN_TIME_NS / CLK_PERIOD_NS;
    localparam int WIN_W = 14;

    // Output frequencies in kHz and the NCO step for each
    localparam int OUT_E1_KHZ = 2048;
    localparam int OUT_T1_KHZ = 1544;
    localparam int CLK_KHZ = 1000000 / CLK_PERIOD_NS;
    localparam int ACC_W = 24;
    localparam longint ACC_ONE = longint'(1) << ACC_W;
    localparam logic [ACC_W-1:0] STEP_E1 =
        ACC_W'((longint'(OUT_E1_KHZ) * ACC_ONE + CLK_KHZ / 2) / CLK_KHZ);
    localparam logic [ACC_W-1:0] STEP_T1 =
        ACC_W'((longint'(OUT_T1_KHZ) * ACC_ONE + CLK_KHZ / 2) / CLK_KHZ);

    // Input select code that takes the 2048k reference from the E1 pin
    localparam logic [2:0] SEL_E1_REF = 3'h0;

    // Rate select values
    localparam logic RATE_E1 = 1'b0;
    localparam logic RATE_T1 = 1'b1;

    // Equalizer bit whose level marks the T1/J1 family when low
    localparam int EQ_FAMILY_BIT = 4;

    // Active synthesizer configuration
    typedef struct packed {
        logic host_mode;
        logic [2:0] in_sel;
        logic rate;
    } mcss_cfg_t;

    // Lock tracking states
    typedef enum logic [0:0] {
        MCSS_HUNT = 1'b0,
        MCSS_LOCK = 1'b1
    } mcss_state_t;

endpackage : mcss_pkg

`timescale 1ns/1ps
`default_nettype none

module mcss_top #(
    parameter int WIN_CYCLES = mcss_pkg::WIN_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // External reference clocks
    input wire logic t1_reference_clock_in,
    input wire logic e1_reference_clock_in,
    // Hardware mode configuration pins
    input wire logic [2:0] synth_input_select,
    input wire logic [4:0] equalizer_control_inputs,
    // Host mode configuration bits
    input wire logic host_mode_sel,
    input wire logic [2:0] host_synth_input_select,
    input wire logic host_output_rate_select,
    // Synthesizer outputs
    output logic synth_master_clock_out,
    output logic synth_locked,
    output logic line_rate_t1
);

    // Synchronised reference levels: bit 1 E1, bit 0 T1
    logic [1:0] ref_lvl;
    // Synchronised configuration pins
    logic [12:0] cfg_lvl;

    // Reference pins pass the three-stage filter
    mcss_sync #(.W(2)) u_ref_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_raw({e1_reference_clock_in, t1_reference_clock_in}),
        .pin_level(ref_lvl)
    );

    // Configuration pins come from the board, so they are filtered too
    mcss_sync #(.W(13)) u_cfg_sync (
        .ref_clk(ref_clk),
        .rst(rst),
        .pin_raw({host_mode_sel, host_synth_input_select, host_output_rate_select,
                  synth_input_select, equalizer_control_inputs}),
        .pin_level(cfg_lvl)
    );

    // Unpacked views of the filtered configuration
    logic hm_lvl; // Host mode
    logic [2:0] hsel_lvl; // Host input select
    logic hrate_lvl; // Host rate
    logic [2:0] psel_lvl; // Pin input select
    logic [4:0] eq_lvl; // Equalizer controls

    assign {hm_lvl, hsel_lvl, hrate_lvl, psel_lvl, eq_lvl} = cfg_lvl;

    // Configuration state
    mcss_pkg::mcss_cfg_t cfg_ff;
    mcss_pkg::mcss_cfg_t nxt_cfg;

    // Pick the configuration source by mode
    always_comb begin
        nxt_cfg.host_mode = hm_lvl;
        if (hm_lvl) begin
            // Pins are ignored; host bits steer the synthesizer
            nxt_cfg.in_sel = hsel_lvl;
            nxt_cfg.rate = hrate_lvl;
        end else begin
            nxt_cfg.in_sel = psel_lvl;
            // Low family bit means a T1/J1 equalizer setting
            if (eq_lvl[mcss_pkg::EQ_FAMILY_BIT]) begin
                nxt_cfg.rate = mcss_pkg::RATE_E1;
            end else begin
                nxt_cfg.rate = mcss_pkg::RATE_T1;
            end
        end
    end

    // Configuration register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= '0;
        end else begin
            cfg_ff <= nxt_cfg;
        end
    end

    // Any change of configuration forces a fresh lock attempt
    logic cfg_change;
    assign cfg_change = (nxt_cfg != cfg_ff);

    // Reference edge tracking and activity window
    logic ref_prev_ff;
    logic nxt_ref_prev;
    logic ref_sel; // Reference chosen by the input select
    logic ref_edge;
    logic [mcss_pkg::WIN_W-1:0] win_cnt_ff;
    logic [mcss_pkg::WIN_W-1:0] nxt_win_cnt;
    logic seen_ff; // An edge was seen in this window
    logic nxt_seen;
    logic win_end;

    // Code 0 takes the 2048k reference from the E1 pin, the rest the T1 pin;
    // with one source strapped to both pins either choice works
    always_comb begin
        if (cfg_ff.in_sel == mcss_pkg::SEL_E1_REF) begin
            ref_sel = ref_lvl[1];
        end else begin
            ref_sel = ref_lvl[0];
        end
    end

    assign ref_edge = ref_sel & ~ref_prev_ff;
    assign win_end = (win_cnt_ff == mcss_pkg::WIN_W'(WIN_CYCLES - 1));

    // Window counter and edge memory; the window restarts on config change
    always_comb begin
        nxt_ref_prev = ref_sel;
        nxt_win_cnt = win_cnt_ff + 1'b1;
        nxt_seen = seen_ff | ref_edge;
        if (cfg_change) begin
            nxt_win_cnt = '0;
            nxt_seen = 1'b0;
        end else if (win_end) begin
            nxt_win_cnt = '0;
            nxt_seen = 1'b0;
        end
    end

    // Window registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ref_prev_ff <= 1'b0;
            win_cnt_ff <= '0;
            seen_ff <= 1'b0;
        end else begin
            ref_prev_ff <= nxt_ref_prev;
            win_cnt_ff <= nxt_win_cnt;
            seen_ff <= nxt_seen;
        end
    end

    // Lock state
    mcss_pkg::mcss_state_t state_ff;
    mcss_pkg::mcss_state_t nxt_state;

    // Lock once a whole window held a reference edge; drop on a dead window
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            mcss_pkg::MCSS_HUNT: begin
                if (!cfg_change && win_end && (seen_ff || ref_edge)) begin
                    nxt_state = mcss_pkg::MCSS_LOCK;
                end
            end
            mcss_pkg::MCSS_LOCK: begin
                if (cfg_change) begin
                    nxt_state = mcss_pkg::MCSS_HUNT;
                end else if (win_end && !(seen_ff || ref_edge)) begin
                    nxt_state = mcss_pkg::MCSS_HUNT;
                end
            end
            default: begin
                nxt_state = mcss_pkg::MCSS_HUNT;
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_ff <= mcss_pkg::MCSS_HUNT;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Phase accumulator that stands in for the PLL
    logic [mcss_pkg::ACC_W-1:0] acc_ff;
    logic [mcss_pkg::ACC_W-1:0] nxt_acc;
    logic [mcss_pkg::ACC_W-1:0] step;
    logic mclk_ff;
    logic nxt_mclk;
    logic lock_ff;
    logic nxt_lock;
    logic rate_ff;
    logic nxt_rate;

    // Step size follows the rate select; jitter is one ref_clk period,
    // which is the price of an all-digital stand-in
    always_comb begin
        if (cfg_ff.rate == mcss_pkg::RATE_T1) begin
            step = mcss_pkg::STEP_T1;
        end else begin
            step = mcss_pkg::STEP_E1;
        end
    end

    // Run only while locked, so no clock leaves without a reference
    always_comb begin
        nxt_acc = '0;
        if (state_ff == mcss_pkg::MCSS_LOCK) begin
            nxt_acc = acc_ff + step;
        end
        nxt_mclk = acc_ff[mcss_pkg::ACC_W-1];
        nxt_lock = (state_ff == mcss_pkg::MCSS_LOCK);
        nxt_rate = cfg_ff.rate;
    end

    // Output registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            acc_ff <= '0;
            mclk_ff <= 1'b0;
            lock_ff <= 1'b0;
            rate_ff <= 1'b0;
        end else begin
            acc_ff <= nxt_acc;
            mclk_ff <= nxt_mclk;
            lock_ff <= nxt_lock;
            rate_ff <= nxt_rate;
        end
    end

    // One rate drives every channel
    assign synth_master_clock_out = mclk_ff;
    assign synth_locked = lock_ff;
    assign line_rate_t1 = rate_ff;

endmodule : mcss_top

`default_nettype wire

// *** mcss_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the synthesizer select block
module mcss_properties #(
    parameter int WIN_CYCLES = 10000
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Reference pins
    input wire logic t1_reference_clock_in,
    input wire logic e1_reference_clock_in,
    // Configuration
    input wire logic [2:0] synth_input_select,
    input wire logic [4:0] equalizer_control_inputs,
    input wire logic host_mode_sel,
    input wire logic [2:0] host_synth_input_select,
    input wire logic host_output_rate_select,
    // Outputs
    input wire logic synth_master_clock_out,
    input wire logic synth_locked,
    input wire logic line_rate_t1
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Host bit in host mode, else a low equalizer bit 4 means T1
    logic exp_rate;
    assign exp_rate = host_mode_sel ? host_output_rate_select : ~equalizer_control_inputs[4];

    // Cycles spent unlocked, saturating at one window
    int unl_cnt;

    // A lock may only rise after a whole window without lock
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            unl_cnt <= 0;
        end else if (synth_locked) begin
            unl_cnt <= 0;
        end else if (unl_cnt < WIN_CYCLES) begin
            unl_cnt <= unl_cnt + 1;
        end
    end

    a_lock_after_window: assert property ($rose(synth_locked) |->
        unl_cnt >= WIN_CYCLES) else $error("lock rose before a full window");

    a_rate_follows_cfg: assert property ($stable(exp_rate)[*8] |=>
        line_rate_t1 == $past(exp_rate)) else $error("line rate wrong");
    // Lock loss may cut a high phase short, so unlocked cycles pass
    a_t1_high_time: assert property ($rose(synth_master_clock_out) && synth_locked
        && line_rate_t1 |-> (synth_master_clock_out || !synth_locked)[*6]
        ##[1:2] !synth_master_clock_out) else $error("T1 high time wrong");
    a_e1_high_time: assert property ($rose(synth_master_clock_out) && synth_locked
        && !line_rate_t1 |-> (synth_master_clock_out || !synth_locked)[*4]
        ##[1:2] !synth_master_clock_out) else $error("E1 high time wrong");
    a_quiet_unlocked: assert property (!synth_locked ##1 !synth_locked
        |-> !synth_master_clock_out) else $error("clock runs unlocked");
    a_eq_change_drops: assert property (!host_mode_sel &&
        $changed(equalizer_control_inputs[4]) |-> ##[1:8] !synth_locked)
        else $error("lock kept over rate change");
    a_host_ignores_pins: assert property (
        $stable({host_mode_sel, host_synth_input_select, host_output_rate_select})[*8]
        ##0 host_mode_sel && synth_locked && $changed(synth_input_select)
        |=> synth_locked[*8]) else $error("host mode obeyed pins");

    c_t1_lock: cover property (synth_locked && line_rate_t1);
    c_e1_lock: cover property (synth_locked && !line_rate_t1);
    c_host_lock: cover property (synth_locked && host_mode_sel);
endmodule : mcss_properties

bind mcss_top mcss_properties #(.WIN_CYCLES(WIN_CYCLES)) u_props (
    .ref_clk(ref_clk),
    .rst(rst),
    .t1_reference_clock_in(t1_reference_clock_in),
    .e1_reference_clock_in(e1_reference_clock_in),
    .synth_input_select(synth_input_select),
    .equalizer_control_inputs(equalizer_control_inputs),
    .host_mode_sel(host_mode_sel),
    .host_synth_input_select(host_synth_input_select),
    .host_output_rate_select(host_output_rate_select),
    .synth_master_clock_out(synth_master_clock_out),
    .synth_locked(synth_locked),
    .line_rate_t1(line_rate_t1)
);

`default_nettype wire

// *** mcss_ref_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// Board reference sources; an absent source reads low (pin pull-down)
module mcss_ref_model (
    // Source controls
    input wire logic t1_on,
    input wire logic e1_on,
    input wire logic single,
    // Reference pins
    output logic t1_reference_clock_in,
    output logic e1_reference_clock_in
);
    logic ck_t1 = 1'b0;
    logic ck_e1 = 1'b0;
    // 1544k source, half period rounded to whole ns
    initial begin
        forever #324 ck_t1 = ~ck_t1;
    end
    // 2048k source
    initial begin
        forever #244 ck_e1 = ~ck_e1;
    end
    assign e1_reference_clock_in = e1_on & ck_e1;
    // One source wired to both pins when only one exists
    assign t1_reference_clock_in = single ? e1_reference_clock_in : t1_on & ck_t1;
endmodule : mcss_ref_model

`default_nettype wire

// *** mcss_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module mcss_top_tb;
    localparam int WIN = 64; // Short window; refs toggle every few cycles
    // Design inputs
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] sel = 3'h0;
    logic [4:0] eq = 5'h10;
    logic hm = 1'b0;
    logic [2:0] hsel = 3'h0;
    logic hrate = 1'b0;
    // Source controls
    logic t1_on = 1'b1;
    logic e1_on = 1'b1;
    logic single = 1'b0;
    // Pins and outputs
    wire logic t1_ref;
    wire logic e1_ref;
    logic mclk;
    logic locked;
    logic rate_t1;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    mcss_ref_model model (.t1_on(t1_on), .e1_on(e1_on), .single(single),
        .t1_reference_clock_in(t1_ref), .e1_reference_clock_in(e1_ref));
    mcss_top #(.WIN_CYCLES(WIN)) dut (.ref_clk(ref_clk), .rst(rst),
        .t1_reference_clock_in(t1_ref), .e1_reference_clock_in(e1_ref),
        .synth_input_select(sel), .equalizer_control_inputs(eq), .host_mode_sel(hm),
        .host_synth_input_select(hsel), .host_output_rate_select(hrate),
        .synth_master_clock_out(mclk), .synth_locked(locked), .line_rate_t1(rate_t1));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end
    // Hang guard, far above the roughly 1150 cycles needed
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 12000) begin
            mismatches++;
            give_verdict();
        end
    end

    // Inputs move and outputs are read 2 ns after the edge
    task automatic tick;
        @(posedge ref_clk);
        #2;
    endtask : tick
    task automatic chk(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %0t got %b want %b", $time, got, exp);
        end
    endtask : chk
    task automatic cfg(input logic h, input logic [2:0] hs, input logic hr,
            input logic [2:0] s, input logic [4:0] e);
        tick();
        hm = h;
        hsel = hs;
        hrate = hr;
        sel = s;
        eq = e;
    endtask : cfg
    // Wait ten cycles for a change to drop lock, then up to four windows to lock
    task automatic settle(input logic lk, input logic rt);
        int i;
        repeat (10) tick();
        for (i = 0; i < 4 * WIN && !(lk && locked === 1'b1); i++) begin
            tick();
        end
        chk(locked, lk);
        chk(rate_t1, rt);
    endtask : settle
    // Whole cycles from one rising edge of the clock output to the next
    task automatic chk_period(input int lo, input int hi);
        int i;
        int n;
        n = 0;
        for (i = 0; i < 30 && mclk !== 1'b0; i++) tick();
        for (i = 0; i < 30 && mclk !== 1'b1; i++) tick();
        for (i = 0; i < 30 && mclk !== 1'b0; i++) begin
            n++;
            tick();
        end
        for (i = 0; i < 30 && mclk !== 1'b1; i++) begin
            n++;
            tick();
        end
        chk(n >= lo && n <= hi, 1'b1);
    endtask : chk_period

    task automatic hw_rates;
        cfg(1'b0, 3'h0, 1'b1, 3'h0, 5'h1f);
        settle(1'b1, 1'b0);
        chk_period(9, 10);
        cfg(1'b0, 3'h0, 1'b0, 3'h1, 5'h0f);
        settle(1'b1, 1'b1);
        chk_period(12, 13);
    endtask : hw_rates
    // Mid-run reset clears every output, then the block locks again
    task automatic mid_reset;
        rst = 1'b1;
        repeat (2) tick();
        chk(locked, 1'b0);
        chk(mclk, 1'b0);
        chk(rate_t1, 1'b0);
        rst = 1'b0;
        settle(1'b1, 1'b1);
        chk_period(12, 13);
    endtask : mid_reset
    // Code 000 listens to the E1 pin only
    task automatic hw_no_e1;
        e1_on = 1'b0;
        cfg(1'b0, 3'h0, 1'b0, 3'h0, 5'h10);
        settle(1'b0, 1'b0);
        chk(mclk, 1'b0);
        cfg(1'b0, 3'h0, 1'b0, 3'h5, 5'h10);
        settle(1'b1, 1'b0);
        e1_on = 1'b1;
    endtask : hw_no_e1
    task automatic host;
        cfg(1'b1, 3'h2, 1'b1, 3'h0, 5'h10);
        settle(1'b1, 1'b1);
        cfg(1'b1, 3'h2, 1'b1, 3'h7, 5'h00);
        repeat (20) tick();
        chk(locked, 1'b1);
        cfg(1'b1, 3'h2, 1'b0, 3'h7, 5'h00);
        settle(1'b1, 1'b0);
        chk_period(9, 10);
    endtask : host
    // One 2048k source on both pins, then the source stops
    task automatic one_src;
        single = 1'b1;
        t1_on = 1'b0;
        cfg(1'b1, 3'h1, 1'b1, 3'h0, 5'h10);
        settle(1'b1, 1'b1);
        e1_on = 1'b0;
        settle(1'b0, 1'b1);
    endtask : one_src

    task automatic give_verdict;
        if (mismatches == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20) tick();
        rst = 1'b0;
        hw_rates();
        mid_reset();
        hw_no_e1();
        host();
        one_src();
        give_verdict();
    end
endmodule : mcss_top_tb

`default_nettype wire
